// File: verilog/ipc_pkg.sv
// -----------------------------------------------------------------------------
// Shared constants and types of the interrupt priority controller.
// -----------------------------------------------------------------------------
package ipc_pkg;

   // Number of user sources and the vector of source zero.
   localparam int          NSRC       = 16;
   localparam int          NPRIO_REG  = 4;
   localparam logic [7:0]  VEC_BASE   = 8'h08;
   localparam logic [23:0] RESET_ADDR = 24'h000000;

   // Register byte offsets on the Wishbone bus.
   localparam logic [7:0] ADR_CTRL1   = 8'h00;
   localparam logic [7:0] ADR_CTRL2   = 8'h04;
   localparam logic [7:0] ADR_CTRL3   = 8'h08;
   localparam logic [7:0] ADR_CTRL4   = 8'h0C;
   localparam logic [7:0] ADR_FLAG    = 8'h10;
   localparam logic [7:0] ADR_ENABLE  = 8'h14;
   localparam logic [7:0] ADR_PRIO0   = 8'h18;
   localparam logic [7:0] ADR_PEND    = 8'h28;
   localparam logic [7:0] ADR_STATUS  = 8'h2C;
   localparam logic [7:0] ADR_CORE    = 8'h30;
   localparam logic [7:0] ADR_EV_STAT = 8'h34;
   localparam logic [7:0] ADR_EV_CLR  = 8'h38;
   localparam logic [7:0] ADR_EV_EN   = 8'h3C;
   localparam logic [7:0] ADR_STEP    = 8'h04;

   // Field positions.
   localparam int NESTING_DISABLE_BIT = 15;
   localparam int GIE_BIT    = 15;
   localparam int EXT_POL    = 0;
   localparam int IPL_LSB    = 5;
   localparam int CPU_LEVEL_MSB_BIT   = 3;
   localparam int VEC_LSB    = 0;
   localparam int ILR_LSB    = 8;
   localparam int PRIO_W     = 3;
   localparam int PRIO_STEP  = 4;

   // Writable masks; bits outside read as zero.
   localparam logic [15:0] CTRL1_MASK = 16'hFFFE;
   localparam logic [15:0] CTRL2_MASK = 16'h8001;
   localparam logic [15:0] CTRL3_MASK = 16'h0007;
   localparam logic [15:0] CTRL4_MASK = 16'h0003;
   localparam logic [15:0] PRIO_MASK  = 16'h7777;
   localparam logic [15:0] RST_WORD   = 16'h0000;

   // Block interrupt events.
   localparam int EV_TRAP = 0;
   localparam int EV_REQ  = 1;
   localparam int EV_TAKE = 2;
   localparam int NEV     = 3;

   // Start-up sequencer states.
   typedef enum logic [1:0] {
      BOOT_HOLD  = 2'b00,
      BOOT_START = 2'b01,
      BOOT_RUN   = 2'b10
   } ipc_boot_e;

   // Vector offered to the CPU core.
   typedef struct packed {
      logic       req;
      logic [3:0] level;
      logic [7:0] vector;
   } ipc_vec_s;

   // Trap event pulses from the core and the system.
   typedef struct packed {
      logic [6:0] core;
      logic       deadman;
      logic       dma;
      logic       do_stack;
      logic       dbl_err;
   } ipc_trap_s;

endpackage

// File: verilog/ipc_arbiter.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Highest-priority selector over the pending sources.
// -----------------------------------------------------------------------------
module ipc_arbiter (
   // Candidate sources and their priority fields
   input  wire logic [ipc_pkg::NSRC-1:0]                 hit,
   input  wire logic [ipc_pkg::NSRC*ipc_pkg::PRIO_W-1:0] prio_flat,
   // Current CPU level
   input  wire logic [3:0]                               level,
   // Winner
   output logic                                          valid,
   output logic [3:0]                                    idx,
   output logic [2:0]                                    prio
);

   // Walk downward so that an equal priority at a lower position replaces
   // the earlier choice, which gives natural order the tie.
   always_comb begin
      logic [2:0] p;
      p     = 3'h0;
      valid = 1'b0;
      idx   = 4'h0;
      prio  = 3'h0;
      for (int i = ipc_pkg::NSRC - 1; i >= 0; i--) begin
         p = prio_flat[i*ipc_pkg::PRIO_W +: ipc_pkg::PRIO_W];
         if (hit[i] && ({1'b0, p} > level) && (!valid || p >= prio)) begin
            valid = 1'b1;
            idx   = 4'(i);
            prio  = p;
         end
      end
   end

endmodule // ipc_arbiter

// File: verilog/ipc_ctrl.sv
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Interrupt priority controller with Wishbone register access.
// -----------------------------------------------------------------------------

module ipc_ctrl (
   // Clock and reset
   input  wire logic                    CORE_CLK,
   input  wire logic                    ARST_N,
   // Wishbone slave
   input  wire logic                    WB_CYC_I,
   input  wire logic                    WB_STB_I,
   input  wire logic                    WB_WE_I,
   input  wire logic [7:0]              WB_ADR_I,
   input  wire logic [3:0]              WB_SEL_I,
   input  wire logic [31:0]             WB_DAT_I,
   output logic      [31:0]             WB_DAT_O,
   output logic                         WB_ACK_O,
   // Request sources
   input  wire logic [ipc_pkg::NSRC-1:1] SRC_REQ,
   input  wire logic                    EXTERNAL_REQUEST_ZERO,
   input  wire ipc_pkg::ipc_trap_s      TRAP_EVT,
   // CPU core side
   output ipc_pkg::ipc_vec_s            IRQ_VEC,
   input  wire logic                    IRQ_TAKE,
   input  wire logic                    TRAP_TAKE,
   input  wire logic [3:0]              TRAP_LEVEL,
   input  wire logic                    RET_VALID,
   input  wire logic [3:0]              RET_LEVEL,
   // Start-up fetch
   output logic      [23:0]             FETCH_ADDR,
   output logic                         FETCH_START,
   // Block interrupt
   output logic                         INT_O
);

   // Merge a written half-word into an old value under the byte selects.
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  sel);
      merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
                 sel[0] ? new_v[7:0]  : old_v[7:0]};
   endfunction

   // --------------------------------------------------------------------------
   // Bus decode
   // --------------------------------------------------------------------------

   logic                        ack_r;
   logic [31:0]                 dat_r;
   logic [15:0]                 c1_r, c2_r, c3_r, c4_r;
   logic [15:0]                 flag_r, en_r, pend_r;
   logic [15:0]                 pr_r [ipc_pkg::NPRIO_REG];
   logic [2:0]                  ipl_r;
   logic                        msb_r;
   logic                        req_r;
   logic                        ext_q_r;
   logic [ipc_pkg::NEV-1:0]     ev_st_r, ev_en_r;
   ipc_pkg::ipc_boot_e          boot_r;

   wire        req_cyc = WB_CYC_I && WB_STB_I && !ack_r;
   wire        wr      = req_cyc && WB_WE_I;
   wire [15:0] wdat    = WB_DAT_I[15:0];
   wire [1:0]  wsel    = WB_SEL_I[1:0];

   // A write only lands once, in the cycle before the ack.
   wire wr_c1    = wr && (WB_ADR_I == ipc_pkg::ADR_CTRL1);
   wire wr_c2    = wr && (WB_ADR_I == ipc_pkg::ADR_CTRL2);
   wire wr_c3    = wr && (WB_ADR_I == ipc_pkg::ADR_CTRL3);
   wire wr_c4    = wr && (WB_ADR_I == ipc_pkg::ADR_CTRL4);
   wire wr_flag  = wr && (WB_ADR_I == ipc_pkg::ADR_FLAG);
   wire wr_en    = wr && (WB_ADR_I == ipc_pkg::ADR_ENABLE);
   wire wr_sr    = wr && (WB_ADR_I == ipc_pkg::ADR_STATUS);
   wire wr_evclr = wr && (WB_ADR_I == ipc_pkg::ADR_EV_CLR);
   wire wr_even  = wr && (WB_ADR_I == ipc_pkg::ADR_EV_EN);

   // --------------------------------------------------------------------------
   // Global control registers
   // --------------------------------------------------------------------------

   wire nesting_disable = c1_r[ipc_pkg::NESTING_DISABLE_BIT];
   wire global_irq_enable    = c2_r[ipc_pkg::GIE_BIT];

   // Hardware set terms are ORed after the write so a set in the same
   // cycle as a clearing write is never lost.
   wire [15:0] c1_set = {8'h00, TRAP_EVT.core, 1'b0};
   wire [15:0] c3_set = {13'h0000, TRAP_EVT.do_stack, TRAP_EVT.dma,
                         TRAP_EVT.deadman};
   wire [15:0] c4_set = {15'h0000, TRAP_EVT.dbl_err};

   wire [15:0] c1_nxt = ((wr_c1 ? merge16(c1_r, wdat, wsel) : c1_r) | c1_set)
                        & ipc_pkg::CTRL1_MASK;
   wire [15:0] c2_nxt = (wr_c2 ? merge16(c2_r, wdat, wsel) : c2_r)
                        & ipc_pkg::CTRL2_MASK;
   wire [15:0] c3_nxt = ((wr_c3 ? merge16(c3_r, wdat, wsel) : c3_r) | c3_set)
                        & ipc_pkg::CTRL3_MASK;
   wire [15:0] c4_nxt = ((wr_c4 ? merge16(c4_r, wdat, wsel) : c4_r) | c4_set)
                        & ipc_pkg::CTRL4_MASK;

   // Control registers all clear on reset.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         c1_r <= ipc_pkg::RST_WORD;
         c2_r <= ipc_pkg::RST_WORD;
         c3_r <= ipc_pkg::RST_WORD;
         c4_r <= ipc_pkg::RST_WORD;
      end else begin
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
         c3_r <= c3_nxt;
         c4_r <= c4_nxt;
      end
   end

   // --------------------------------------------------------------------------
   // Source flags, enables and priorities
   // --------------------------------------------------------------------------

   // External request zero is edge detected; the polarity bit picks falling.
   wire ext_edge = c2_r[ipc_pkg::EXT_POL] ? (ext_q_r && !EXTERNAL_REQUEST_ZERO)
                                          : (!ext_q_r && EXTERNAL_REQUEST_ZERO);

   // Natural order: source zero is the external request at flag bit zero.
   wire [15:0] src_set  = {SRC_REQ, ext_edge};
   wire [15:0] flag_nxt = (wr_flag ? merge16(flag_r, wdat, wsel) : flag_r)
                          | src_set;
   wire [15:0] en_nxt   = wr_en ? merge16(en_r, wdat, wsel) : en_r;

   // Flags and enables.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         flag_r  <= ipc_pkg::RST_WORD;
         en_r    <= ipc_pkg::RST_WORD;
         ext_q_r <= 1'b0;
      end else begin
         flag_r  <= flag_nxt;
         en_r    <= en_nxt;
         ext_q_r <= EXTERNAL_REQUEST_ZERO;
      end
   end

   logic [ipc_pkg::NSRC*ipc_pkg::PRIO_W-1:0] prio_flat;

   // Four priority registers, four three-bit fields each.
   for (genvar r = 0; r < ipc_pkg::NPRIO_REG; r++) begin : g_prio
      wire [7:0] adr_r = ipc_pkg::ADR_PRIO0 + 8'(r * ipc_pkg::ADR_STEP);
      wire       wr_pr = wr && (WB_ADR_I == adr_r);

      always_ff @(posedge CORE_CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            pr_r[r] <= ipc_pkg::RST_WORD;
         end else if (wr_pr) begin
            pr_r[r] <= merge16(pr_r[r], wdat, wsel) & ipc_pkg::PRIO_MASK;
         end
      end

      for (genvar f = 0; f < ipc_pkg::NPRIO_REG; f++) begin : g_fld
         assign prio_flat[(r*ipc_pkg::NPRIO_REG+f)*ipc_pkg::PRIO_W +: ipc_pkg::PRIO_W] =
            pr_r[r][f*ipc_pkg::PRIO_STEP +: ipc_pkg::PRIO_W];
      end
   end

   // --------------------------------------------------------------------------
   // Selection and pending vector
   // --------------------------------------------------------------------------

   logic       arb_valid;
   logic [3:0] arb_idx;
   logic [2:0] arb_prio;

   // Only enabled flags compete, and none at all while the top level bit
   // is set or the global enable is off.
   wire        block = msb_r || !global_irq_enable;
   wire [15:0] hit   = (flag_r & en_r) & {16{!block}};
   wire [3:0]  level = {msb_r, ipl_r};

   ipc_arbiter u_arb (
      .hit       (hit),
      .prio_flat (prio_flat),
      .level     (level),
      .valid     (arb_valid),
      .idx       (arb_idx),
      .prio      (arb_prio)
   );

   wire [7:0]  vec_num  = ipc_pkg::VEC_BASE + {4'h0, arb_idx};
   wire [15:0] pend_nxt = arb_valid ? {4'h0, 1'b0, arb_prio, vec_num} : pend_r;

   // The last winner stays latched until a new one appears.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pend_r <= ipc_pkg::RST_WORD;
         req_r  <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         req_r  <= arb_valid;
      end
   end

   assign IRQ_VEC = '{req:    req_r,
                      level:  pend_r[ipc_pkg::ILR_LSB +: 4],
                      vector: pend_r[ipc_pkg::VEC_LSB +: 8]};

   // --------------------------------------------------------------------------
   // CPU priority level
   // --------------------------------------------------------------------------

   // Traps win over vectors, vectors over returns, and all over software.
   wire       take   = IRQ_TAKE && req_r;
   wire       sw_ipl = wr_sr && wsel[0] && !nesting_disable;
   wire [3:0] lvl_nxt = TRAP_TAKE ? TRAP_LEVEL :
                        take      ? pend_r[ipc_pkg::ILR_LSB +: 4] :
                        RET_VALID ? RET_LEVEL :
                        sw_ipl    ? {msb_r, wdat[ipc_pkg::IPL_LSB +: 3]} :
                                    level;

   // Level register; the top bit has no software write path.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ipl_r <= 3'h0;
         msb_r <= 1'b0;
      end else begin
         ipl_r <= lvl_nxt[2:0];
         msb_r <= lvl_nxt[3];
      end
   end

   // --------------------------------------------------------------------------
   // Block interrupt status
   // --------------------------------------------------------------------------

   wire [ipc_pkg::NEV-1:0] ev;
   assign ev[ipc_pkg::EV_TRAP] = |c1_set || |c3_set || |c4_set;
   assign ev[ipc_pkg::EV_REQ]  = |src_set;
   assign ev[ipc_pkg::EV_TAKE] = take;

   wire [ipc_pkg::NEV-1:0] ev_clr = wr_evclr ? WB_DAT_I[ipc_pkg::NEV-1:0] : '0;

   // Set wins over a clear arriving in the same cycle.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ev_st_r <= '0;
         ev_en_r <= '0;
      end else begin
         ev_st_r <= (ev_st_r & ~ev_clr) | ev;
         ev_en_r <= wr_even ? WB_DAT_I[ipc_pkg::NEV-1:0] : ev_en_r;
      end
   end

   assign INT_O = |(ev_st_r & ev_en_r);

   // --------------------------------------------------------------------------
   // Read mux and acknowledge
   // --------------------------------------------------------------------------

   wire [15:0] sr_word   = {8'h00, ipl_r, 5'h00};
   wire [15:0] core_word = {12'h000, msb_r, 3'h0};
   wire [15:0] pr_word   = pr_r[WB_ADR_I[3:2] - 2'(ipc_pkg::ADR_PRIO0 >> 2)];
   wire        is_pr     = (WB_ADR_I >= ipc_pkg::ADR_PRIO0) &&
                           (WB_ADR_I < ipc_pkg::ADR_PEND) && (WB_ADR_I[1:0] == 2'b00);

   // Unmapped and write-only addresses read as zero.
   wire [15:0] rd_word =
      (WB_ADR_I == ipc_pkg::ADR_CTRL1)   ? c1_r      :
      (WB_ADR_I == ipc_pkg::ADR_CTRL2)   ? c2_r      :
      (WB_ADR_I == ipc_pkg::ADR_CTRL3)   ? c3_r      :
      (WB_ADR_I == ipc_pkg::ADR_CTRL4)   ? c4_r      :
      (WB_ADR_I == ipc_pkg::ADR_FLAG)    ? flag_r    :
      (WB_ADR_I == ipc_pkg::ADR_ENABLE)  ? en_r      :
      is_pr                              ? pr_word   :
      (WB_ADR_I == ipc_pkg::ADR_PEND)    ? pend_r    :
      (WB_ADR_I == ipc_pkg::ADR_STATUS)  ? sr_word   :
      (WB_ADR_I == ipc_pkg::ADR_CORE)    ? core_word :
      (WB_ADR_I == ipc_pkg::ADR_EV_STAT) ? {13'h0000, ev_st_r} :
      (WB_ADR_I == ipc_pkg::ADR_EV_EN)   ? {13'h0000, ev_en_r} :
                                           16'h0000;

   // One wait state: ack and data rise together one edge after the request.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req_cyc;
         dat_r <= {16'h0000, rd_word};
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;

   // --------------------------------------------------------------------------
   // Start-up fetch
   // --------------------------------------------------------------------------

   // Runs from reset alone, so start-up never waits on the vector path.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         boot_r <= ipc_pkg::BOOT_HOLD;
      end else begin
         case (boot_r)
            ipc_pkg::BOOT_HOLD:  boot_r <= ipc_pkg::BOOT_START;
            ipc_pkg::BOOT_START: boot_r <= ipc_pkg::BOOT_RUN;
            ipc_pkg::BOOT_RUN:   boot_r <= ipc_pkg::BOOT_RUN;
            default:             boot_r <= ipc_pkg::BOOT_HOLD;
         endcase
      end
   end

   assign FETCH_START = (boot_r == ipc_pkg::BOOT_START);
   assign FETCH_ADDR  = ipc_pkg::RESET_ADDR;

   // --------------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------------

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_take;
      IRQ_TAKE && req_r && !TRAP_TAKE;
   endsequence

   sequence s_level_loaded;
      ##1 (level == $past(pend_r[ipc_pkg::ILR_LSB +: 4]));
   endsequence

   flag_set_a: assert property ((src_set != 16'h0000) |=>
      ((flag_r & $past(src_set)) == $past(src_set)))
      else $error("A source request did not set its flag.");

   enable_gate_a: assert property (arb_valid |->
      (flag_r[arb_idx] && en_r[arb_idx]))
      else $error("A disabled or idle source won arbitration.");

   pend_latch_a: assert property (arb_valid |=>
      (pend_r[7:0] == $past(vec_num)) && (pend_r[11:8] == {1'b0, $past(arb_prio)}))
      else $error("Pending vector register did not latch the winner.");

   msb_block_a: assert property (msb_r |-> !arb_valid ##1 !req_r)
      else $error("User request offered while top level bit set.");

   level7_block_a: assert property ((ipl_r == 3'h7) |-> !arb_valid)
      else $error("User request won at level seven.");

   nest_ro_a: assert property ((nesting_disable && wr_sr && !TRAP_TAKE && !take &&
      !RET_VALID) |=> $stable(ipl_r))
      else $error("Level bits changed by software under nesting disable.");

   take_level_a: assert property (s_take |-> s_level_loaded)
      else $error("Taking a vector did not load its level.");

   fetch_once_a: assert property (FETCH_START |=> !FETCH_START [*3])
      else $error("Start fetch pulse repeated.");

   gie_gate_a: assert property (!global_irq_enable |-> !arb_valid)
      else $error("Request offered with global enable off.");

endmodule // ipc_ctrl

// File: tb/ipc_core_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// CPU core stand-in that takes offered vectors.
// -----------------------------------------------------------------------------
module ipc_core_model (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Vector side
   input  wire logic              take_en,
   input  wire ipc_pkg::ipc_vec_s vec,
   output logic                   take
);
   logic [1:0] dly_r;

   // A random pause of up to three cycles shows whether the offer is held.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         take  <= 1'b0;
         dly_r <= 2'b00;
      end else if (take || !(take_en && vec.req)) begin
         take  <= 1'b0;
         dly_r <= 2'($urandom_range(3));
      end else if (dly_r != 2'b00) begin
         dly_r <= dly_r - 2'b01;
      end else begin
         // Every vector number owns a handler here, so any offer is taken.
         take  <= 1'b1;
      end
   end
endmodule // ipc_core_model

// File: tb/tb_interrupt_priority_control.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Random and corner tests of the interrupt controller.
// -----------------------------------------------------------------------------
module tb_interrupt_priority_control;
   logic               clk, rst_n, cyc, stb, we, ext0, ten, ttk, rv, ack, io, fs, tk;
   logic [7:0]         adr;
   logic [31:0]        wd, rd;
   logic [14:0]        src;
   logic [23:0]        fa;
   logic [3:0]         tl, rl;
   ipc_pkg::ipc_trap_s trap;
   ipc_pkg::ipc_vec_s  vec;
   logic [2:0]         pr[16];
   logic [15:0]        q, d, m, en;
   logic [12:0]        e;
   int                 miscompares = 0, comparisons = 0, cnt = 0;

   ipc_ctrl dut (.CORE_CLK(clk), .ARST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wd), .WB_DAT_O(rd),
      .WB_ACK_O(ack), .SRC_REQ(src), .EXTERNAL_REQUEST_ZERO(ext0), .TRAP_EVT(trap),
      .IRQ_VEC(vec), .IRQ_TAKE(tk), .TRAP_TAKE(ttk), .TRAP_LEVEL(tl), .RET_VALID(rv),
      .RET_LEVEL(rl), .FETCH_ADDR(fa), .FETCH_START(fs), .INT_O(io));
   ipc_core_model core (.clk(clk), .rst_n(rst_n), .take_en(ten), .vec(vec), .take(tk));

   // Clock and a cycle ceiling; the tests need well under a thousand cycles.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cnt++;
      if (cnt == 20000) begin
         miscompares++;
         summarize();
      end
   end

   task automatic summarize;
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [15:0] x, input logic [15:0] g);
      comparisons++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", s, x, g);
      end
   endtask

   // Classic single cycle; the request stands until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] dat);
      @(posedge clk);
      {cyc, stb, we, adr, wd} <= {2'b11, w, a, 16'h0000, dat};
      while (ack !== 1'b1) @(posedge clk);
      q = rd[15:0];
      {cyc, stb} <= 2'b00;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] x);
      wb(1'b0, a, 16'h0000);
      chk($sformatf("reg %h", a), x, q);
   endtask

   // Expected winner as {found, level, vector}; a tie keeps the lower source.
   function automatic logic [12:0] best(input logic [15:0] p, input logic [3:0] lvl);
      logic [12:0] r = '0;
      for (int i = 0; i < 16; i++)
         if (p[i] && {1'b0, pr[i]} > lvl && pr[i] > r[10:8]) r = {2'b10, pr[i], 8'h08 + 8'(i)};
      return r;
   endfunction

   // Main sequence.
   initial begin
      {cyc, stb, we, adr, wd, src, ext0, trap, ttk, tl, rv, rl, ten} = '0;
      rst_n = 1'b0;
      void'($urandom(32'hA373));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 chk("start", 16'h0001, {fa[23:16] | fa[15:8] | fa[7:0], 7'h00, fs});
      @(posedge clk);
      #1 chk("start end", 16'h0000, {15'h0000, fs});
      for (int a = 0; a < 17; a++) rchk(8'(a * 4), 16'h0000);
      wb(1'b1, ipc_pkg::ADR_CTRL2, 16'h8000);
      rchk(ipc_pkg::ADR_CTRL2, 16'h8000);
      for (int i = 0; i < 4; i++) begin
         d = 16'($urandom) & ipc_pkg::PRIO_MASK;
         wb(1'b1, ipc_pkg::ADR_PRIO0 + 8'(4 * i), d);
         rchk(ipc_pkg::ADR_PRIO0 + 8'(4 * i), d);
         for (int j = 0; j < 4; j++) pr[4 * i + j] = d[4 * j +: 3];
      end
      for (int k = 0; k < 8; k++) begin
         en = 16'($urandom);
         m = 16'($urandom) & 16'hFFFE;
         wb(1'b1, ipc_pkg::ADR_ENABLE, en);
         wb(1'b1, ipc_pkg::ADR_FLAG, 16'h0000);
         src <= m[15:1];
         @(posedge clk);
         src <= '0;
         repeat (3) @(posedge clk);
         rchk(ipc_pkg::ADR_FLAG, m);
         e = best(m & en, 4'h0);
         chk("offer", {15'h0000, e[12]}, {15'h0000, vec.req});
         if (e[12]) rchk(ipc_pkg::ADR_PEND, {4'h0, e[11:0]});
         if (e[12]) chk("vector", {4'h0, e[11:0]}, {4'h0, vec.level, vec.vector});
      end
      // Equal priorities everywhere: the external request zero must win.
      for (int i = 0; i < 4; i++) wb(1'b1, ipc_pkg::ADR_PRIO0 + 8'(4 * i), 16'h5555);
      wb(1'b1, ipc_pkg::ADR_ENABLE, 16'hFFFF);
      ext0 <= 1'b1;
      src <= '1;
      @(posedge clk);
      src <= '0;
      repeat (3) @(posedge clk);
      rchk(ipc_pkg::ADR_PEND, 16'h0508);
      wb(1'b1, ipc_pkg::ADR_STATUS, 16'h00A0);
      rchk(ipc_pkg::ADR_STATUS, 16'h00A0);
      chk("offer", 16'h0000, {15'h0000, vec.req});
      wb(1'b1, ipc_pkg::ADR_STATUS, 16'h0080);
      rchk(ipc_pkg::ADR_STATUS, 16'h0080);
      chk("offer", 16'h0001, {15'h0000, vec.req});
      wb(1'b1, ipc_pkg::ADR_CTRL1, 16'h8000);
      wb(1'b1, ipc_pkg::ADR_STATUS, 16'h00E0);
      rchk(ipc_pkg::ADR_STATUS, 16'h0080);
      wb(1'b1, ipc_pkg::ADR_CTRL1, 16'h0000);
      wb(1'b1, ipc_pkg::ADR_STATUS, 16'h00E0);
      rchk(ipc_pkg::ADR_STATUS, 16'h00E0);
      chk("offer", 16'h0000, {15'h0000, vec.req});
      wb(1'b1, ipc_pkg::ADR_CORE, 16'h0008);
      rchk(ipc_pkg::ADR_CORE, 16'h0000);
      {ttk, tl} <= 5'h18;
      @(posedge clk);
      ttk <= 1'b0;
      rchk(ipc_pkg::ADR_CORE, 16'h0008);
      rchk(ipc_pkg::ADR_STATUS, 16'h0000);
      chk("offer", 16'h0000, {15'h0000, vec.req});
      {rv, rl} <= 5'h10;
      @(posedge clk);
      rv <= 1'b0;
      rchk(ipc_pkg::ADR_STATUS, 16'h0000);
      chk("offer", 16'h0001, {15'h0000, vec.req});
      ten <= 1'b1;
      while (vec.req !== 1'b0) @(posedge clk);
      ten <= 1'b0;
      rchk(ipc_pkg::ADR_STATUS, 16'h00A0);
      trap <= '1;
      @(posedge clk);
      trap <= '0;
      rchk(ipc_pkg::ADR_CTRL1, 16'h00FE);
      rchk(ipc_pkg::ADR_CTRL3, 16'h0007);
      rchk(ipc_pkg::ADR_CTRL4, 16'h0001);
      rchk(ipc_pkg::ADR_EV_STAT, 16'h0007);
      chk("irq", 16'h0000, {15'h0000, io});
      wb(1'b1, ipc_pkg::ADR_EV_EN, 16'h0007);
      rchk(ipc_pkg::ADR_EV_EN, 16'h0007);
      chk("irq", 16'h0001, {15'h0000, io});
      wb(1'b1, ipc_pkg::ADR_EV_CLR, 16'h0006);
      rchk(ipc_pkg::ADR_EV_STAT, 16'h0001);
      wb(1'b1, ipc_pkg::ADR_EV_EN, 16'h0006);
      rchk(ipc_pkg::ADR_EV_EN, 16'h0006);
      chk("irq", 16'h0000, {15'h0000, io});
      // Falling polarity: a high-to-low step on request zero sets flag zero.
      wb(1'b1, ipc_pkg::ADR_FLAG, 16'h0000);
      wb(1'b1, ipc_pkg::ADR_CTRL2, 16'h8001);
      ext0 <= 1'b0;
      repeat (2) @(posedge clk);
      rchk(ipc_pkg::ADR_FLAG, 16'h0001);
      chk("irq", 16'h0001, {15'h0000, io});
      summarize();
   end
endmodule // tb_interrupt_priority_control
